// ==== hdl/mar_avg.sv ====
// Running sum of sixteen signed conversions for the remote diode channel
`timescale 1ns/1ps
`default_nettype none
module mar_avg
  import mar_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic clr,
  input wire logic add,
  input wire logic [7:0] sample,
  output logic [7:0] avg_out,
  output logic last
);
  logic [11:0] sum, next_sum, total;
  logic [3:0] cnt, next_cnt;

  always_comb begin
    total = sum + {{4{sample[7]}}, sample};
    avg_out = total[11:4];
    last = (cnt == AVG_LAST);
    next_sum = sum;
    next_cnt = cnt;
    if (clr || (add && last)) begin
      next_sum = 12'h000;
      next_cnt = 4'h0;
    end else if (add) begin
      next_sum = total;
      next_cnt = cnt + 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sum <= 12'h000;
      cnt <= 4'h0;
    end else begin
      sum <= next_sum;
      cnt <= next_cnt;
    end
  end
endmodule : mar_avg
`default_nettype wire

// ==== hdl/mar_monitor.sv ====
// Measurement sequencing, result registers and serial register access
`timescale 1ns/1ps
`default_nettype none
// Function
// - First byte of every write loads the register pointer; second byte writes data.
// - A read without pointer write returns the selected register, pointer unchanged.
// - Slave address is 01011 followed by two bits from the address-select pin.
// - Send byte, receive byte and read byte transactions are all accepted.
// - Five voltages, remote diode, own supply and local temperature are measured.
// - One shared converter gives eight-bit results for every channel.
// - Nominal supply produces code 192, leaving headroom above it.
// - Voltage results are unsigned 0 to 255, clamped at both ends.
// - Each channel except remote diode is converted in an 11.6 ms slot, once per 116 ms round.
// - Remote result averages 16 conversions, nominally 34.8 ms per measurement.
// - Local temperature result is stored at register 27h.
// - Temperatures are two's complement, one degree per bit, -128 to +127.
// - Remote diode temperature uses the same eight-bit two's complement format.
// - Remote diode fault sets bit 6 of status register 42h.
// - Config bit 0 set starts round-robin conversions until it is cleared.
// - Status bit set when out of limits, cleared within; reads leave it.
module mar_monitor
  import mar_pkg::*;
#(
  parameter int CONV_CYC = CONV_CYCLES,
  parameter int REMOTE_SUB_CYC = REMOTE_SUB_CYCLES
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic SCL,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE_N,
  input wire logic SLAVE_ADDR_BIT1,
  input wire logic SLAVE_ADDR_BIT0,
  input wire logic DIODE_FAULT,
  input wire logic ADC_DONE,
  input wire logic [7:0] ADC_DATA,
  output logic ADC_START,
  output logic [2:0] ADC_CHANNEL
);
  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic start_p, stop_p, byte_done;
  logic [7:0] rx_byte;
  logic a1_m, a1_s, a0_m, a0_s, fault_m, fault_s;

  mar_proto_t pstate, next_pstate;
  logic [7:0] ptr, next_ptr, tx_byte, next_tx, rd_data;
  logic ack_req, next_ack, tx_mode, next_txm;
  logic [1:0] addr_lo, next_lo;
  logic addr_locked, next_lk;
  logic [7:0] cfg, next_cfg;
  logic [7:0] lim [16];
  logic [7:0] next_lim [16];
  logic [3:0] lim_idx;

  mar_seq_t sstate, next_sstate;
  logic [2:0] ch, next_ch, next_adc_ch;
  logic [TIMER_W-1:0] timer, next_timer;
  logic [7:0] result, next_result, store_val;
  logic have, next_have, fault_seen, next_fault_seen, next_adc_start;
  logic do_store, avg_add, avg_clr, avg_last;
  logic [7:0] avg_out;
  logic [7:0] value [8];
  logic [7:0] next_value [8];
  logic [7:0] status1, next_status1, status2, next_status2;
  logic run;

  function automatic logic in_limits(input logic [7:0] a);
    return (a >= REG_LIMIT_BASE) && (a <= REG_LIMIT_LAST);
  endfunction : in_limits

  // ---------------------------------------------------------------
  // Sub-blocks
  // ---------------------------------------------------------------
  mar_smb_bit i_mar_smb_bit (
    .clk(CLK),
    .rst(RESET),
    .scl_pin(SCL),
    .sda_pin(SDA_IN),
    .ack_req(ack_req),
    .tx_mode(tx_mode),
    .tx_byte(tx_byte),
    .start_p(start_p),
    .stop_p(stop_p),
    .byte_done(byte_done),
    .rx_byte(rx_byte),
    .sda_oe_n(SDA_OE_N)
  );

  mar_avg i_mar_avg (
    .clk(CLK),
    .rst(RESET),
    .clr(avg_clr),
    .add(avg_add),
    .sample(result),
    .avg_out(avg_out),
    .last(avg_last)
  );

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge CLK) begin
    a1_m <= SLAVE_ADDR_BIT1;
    a1_s <= a1_m;
    a0_m <= SLAVE_ADDR_BIT0;
    a0_s <= a0_m;
    fault_m <= DIODE_FAULT;
    fault_s <= fault_m;
  end

  // ---------------------------------------------------------------
  // Register read mux
  // ---------------------------------------------------------------
  assign lim_idx = 4'(ptr - REG_LIMIT_BASE);
  assign run = cfg[CFG_START_BIT];

  always_comb begin
    rd_data = REG_UNMAPPED;
    if (ptr[7:3] == REG_VALUE_BASE[7:3]) begin
      rd_data = value[ptr[2:0]];
    end else if (in_limits(ptr)) begin
      rd_data = lim[lim_idx];
    end else begin
      case (ptr)
        REG_CONFIG: rd_data = cfg;
        REG_STATUS1: rd_data = status1;
        REG_STATUS2: rd_data = status2;
        default: rd_data = REG_UNMAPPED;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Transaction layer
  // ---------------------------------------------------------------
  always_comb begin
    next_pstate = pstate;
    next_ptr = ptr;
    next_ack = ack_req;
    next_txm = tx_mode;
    next_tx = tx_byte;
    next_cfg = cfg;
    next_lim = lim;
    next_lo = addr_lo;
    next_lk = addr_locked;
    if (start_p) begin
      next_pstate = PS_ADDR;
      next_txm = 1'b0;
      next_ack = 1'b0;
      if (!addr_locked) begin
        next_lo = {a1_s, a0_s};
        next_lk = 1'b1;
      end
    end else if (stop_p) begin
      next_pstate = PS_IDLE;
      next_txm = 1'b0;
      next_ack = 1'b0;
    end else if (byte_done) begin
      case (pstate)
        PS_ADDR: begin
          if (rx_byte[7:1] == {ADDR_UPPER, addr_lo}) begin
            next_ack = 1'b1;
            if (rx_byte[0]) begin
              next_pstate = PS_READ;
              next_txm = 1'b1;
              next_tx = rd_data;
            end else begin
              next_pstate = PS_PTR;
            end
          end else begin
            next_ack = 1'b0;
            next_pstate = PS_SKIP;
          end
        end
        PS_PTR: begin
          next_ptr = rx_byte;
          next_ack = 1'b1;
          next_pstate = PS_DATA;
        end
        PS_DATA: begin
          next_ack = 1'b1;
          if (ptr == REG_CONFIG) begin
            next_cfg = rx_byte;
          end else if (in_limits(ptr)) begin
            next_lim[lim_idx] = rx_byte;
          end
        end
        PS_READ: begin
          next_ack = 1'b0;
          next_tx = rd_data;
        end
        default: begin
          next_ack = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    SDA_OUT <= 1'b0;
    if (RESET) begin
      pstate <= PS_IDLE;
      ptr <= REG_UNMAPPED;
      ack_req <= 1'b0;
      tx_mode <= 1'b0;
      tx_byte <= 8'h00;
      addr_lo <= 2'h0;
      addr_locked <= 1'b0;
      cfg <= CONFIG_RESET;
      for (int i = 0; i < 8; i++) begin
        lim[2*i] <= mar_is_temp(3'(i)) ? LIM_HI_TEMP_RESET : LIM_HI_VOLT_RESET;
        lim[2*i+1] <= mar_is_temp(3'(i)) ? LIM_LO_TEMP_RESET : LIM_LO_VOLT_RESET;
      end
    end else begin
      pstate <= next_pstate;
      ptr <= next_ptr;
      ack_req <= next_ack;
      tx_mode <= next_txm;
      tx_byte <= next_tx;
      addr_lo <= next_lo;
      addr_locked <= next_lk;
      cfg <= next_cfg;
      lim <= next_lim;
    end
  end

  // ---------------------------------------------------------------
  // Measurement sequencer
  // ---------------------------------------------------------------
  always_comb begin
    next_sstate = sstate;
    next_ch = ch;
    next_timer = timer;
    next_result = result;
    next_have = have;
    next_fault_seen = fault_seen;
    next_adc_start = 1'b0;
    next_adc_ch = ADC_CHANNEL;
    next_value = value;
    next_status1 = status1;
    next_status2 = status2;
    avg_add = 1'b0;
    avg_clr = 1'b0;
    do_store = 1'b0;
    store_val = result;
    case (sstate)
      SQ_IDLE: begin
        if (run) begin
          next_ch = CH_FIRST;
          avg_clr = 1'b1;
          next_fault_seen = 1'b0;
          next_sstate = SQ_START;
        end
      end
      SQ_START: begin
        next_adc_start = 1'b1;
        next_adc_ch = ch;
        next_have = 1'b0;
        // This start cycle is the first cycle of the slot
        if (ch == CH_REMOTE) begin
          next_timer = TIMER_W'(REMOTE_SUB_CYC - 2);
        end else begin
          next_timer = TIMER_W'(CONV_CYC - 2);
        end
        next_sstate = SQ_WAIT;
      end
      SQ_WAIT: begin
        if (ADC_DONE && !have) begin
          next_result = ADC_DATA;
          next_have = 1'b1;
        end
        if (ch == CH_REMOTE && fault_s) begin
          next_fault_seen = 1'b1;
        end
        if (timer != '0) begin
          next_timer = timer - 1'b1;
        end else if (have) begin
          if (ch == CH_REMOTE) begin
            avg_add = 1'b1;
            if (avg_last) begin
              do_store = 1'b1;
              store_val = avg_out;
              next_status2[ST2_FAULT_BIT] = fault_seen | fault_s;
              next_fault_seen = 1'b0;
            end else begin
              next_sstate = SQ_START;
            end
          end else begin
            do_store = 1'b1;
          end
        end
      end
      default: begin
        next_sstate = SQ_IDLE;
      end
    endcase
    if (do_store) begin
      // Local channel index maps onto register 27h
      next_value[ch] = store_val;
      next_status1[ch] = mar_out_of_limit(ch, store_val, lim[{ch, 1'b0}],
                                          lim[{ch, 1'b1}]);
      next_ch = ch + 3'h1;
      next_sstate = run ? SQ_START : SQ_IDLE;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      sstate <= SQ_IDLE;
      ch <= CH_FIRST;
      timer <= '0;
      result <= VALUE_RESET;
      have <= 1'b0;
      fault_seen <= 1'b0;
      ADC_START <= 1'b0;
      ADC_CHANNEL <= CH_FIRST;
      status1 <= STATUS_RESET;
      status2 <= STATUS_RESET;
      for (int i = 0; i < 8; i++) begin
        value[i] <= VALUE_RESET;
      end
    end else begin
      sstate <= next_sstate;
      ch <= next_ch;
      timer <= next_timer;
      result <= next_result;
      have <= next_have;
      fault_seen <= next_fault_seen;
      ADC_START <= next_adc_start;
      ADC_CHANNEL <= next_adc_ch;
      status1 <= next_status1;
      status2 <= next_status2;
      value <= next_value;
    end
  end
endmodule : mar_monitor
`default_nettype wire

// ==== hdl/mar_smb_bit.sv ====
// Serial bus bit engine: pin sync, start/stop detection, shifting, acknowledge
`timescale 1ns/1ps
`default_nettype none
module mar_smb_bit
  import mar_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic scl_pin,
  input wire logic sda_pin,
  input wire logic ack_req,
  input wire logic tx_mode,
  input wire logic [7:0] tx_byte,
  output logic start_p,
  output logic stop_p,
  output logic byte_done,
  output logic [7:0] rx_byte,
  output logic sda_oe_n
);
  logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
  logic active, next_active, nacked, next_nacked, next_oe_n;
  logic next_start, next_stop, next_done, scl_rise, scl_fall;
  logic [3:0] cnt, next_cnt;
  logic [7:0] next_rx;

  always_comb begin
    scl_rise = scl_s & ~scl_d;
    scl_fall = ~scl_s & scl_d;
    next_start = scl_s & scl_d & sda_d & ~sda_s;
    next_stop = scl_s & scl_d & ~sda_d & sda_s;
    next_active = active;
    next_nacked = nacked;
    next_cnt = cnt;
    next_rx = rx_byte;
    next_oe_n = sda_oe_n;
    next_done = 1'b0;
    if (next_start || next_stop) begin
      next_active = next_start;
      next_nacked = 1'b0;
      next_cnt = 4'h0;
      next_oe_n = 1'b1;
    end else if (active) begin
      if (scl_rise) begin
        if (cnt == 4'h8) begin
          next_cnt = 4'h0;
          // Master not-acknowledge ends a read: stop driving data
          next_nacked = tx_mode & sda_s;
        end else begin
          next_rx = {rx_byte[6:0], sda_s};
          next_cnt = cnt + 4'h1;
          next_done = (cnt == 4'h7);
        end
      end
      if (scl_fall) begin
        if (cnt == 4'h8) begin
          next_oe_n = ~ack_req;
        end else if (tx_mode && !nacked) begin
          next_oe_n = tx_byte[3'(3'h7 - cnt[2:0])];
        end else begin
          next_oe_n = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    scl_m <= scl_pin;
    scl_s <= scl_m;
    sda_m <= sda_pin;
    sda_s <= sda_m;
    if (rst) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      active <= 1'b0;
      nacked <= 1'b0;
      cnt <= 4'h0;
      rx_byte <= 8'h00;
      sda_oe_n <= 1'b1;
      start_p <= 1'b0;
      stop_p <= 1'b0;
      byte_done <= 1'b0;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
      active <= next_active;
      nacked <= next_nacked;
      cnt <= next_cnt;
      rx_byte <= next_rx;
      sda_oe_n <= next_oe_n;
      start_p <= next_start;
      stop_p <= next_stop;
      byte_done <= next_done;
    end
  end
endmodule : mar_smb_bit
`default_nettype wire

// ==== pkg/mar_pkg.sv ====
// Constants, types and helpers shared by the monitor result logic
package mar_pkg;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 20_000_000;
  localparam int CLK_PER_US = CLK_HZ / 1_000_000;
  localparam int CONV_TIME_US = 11600;
  localparam int REMOTE_TIME_US = 34800;
  localparam int AVG_COUNT = 16;
  localparam int CONV_CYCLES = CONV_TIME_US * CLK_PER_US;
  localparam int REMOTE_SUB_CYCLES = REMOTE_TIME_US * CLK_PER_US / AVG_COUNT;
  localparam int TIMER_W = 18;
  localparam logic [3:0] AVG_LAST = 4'hF;

  // ---------------------------------------------------------------
  // Serial address and register map
  // ---------------------------------------------------------------
  localparam logic [4:0] ADDR_UPPER = 5'h0B;
  localparam logic [7:0] REG_VALUE_BASE = 8'h20;
  localparam logic [7:0] REG_LOCAL_TEMP = 8'h27;
  localparam logic [7:0] REG_LIMIT_BASE = 8'h2B;
  localparam logic [7:0] REG_LIMIT_LAST = 8'h3A;
  localparam logic [7:0] REG_CONFIG = 8'h40;
  localparam logic [7:0] REG_STATUS1 = 8'h41;
  localparam logic [7:0] REG_STATUS2 = 8'h42;
  localparam logic [7:0] REG_UNMAPPED = 8'h00;
  localparam int CFG_START_BIT = 0;
  localparam int ST2_FAULT_BIT = 6;

  // ---------------------------------------------------------------
  // Channels and reset values
  // ---------------------------------------------------------------
  localparam logic [2:0] CH_FIRST = 3'h0;
  localparam logic [2:0] CH_REMOTE = 3'h6;
  localparam logic [2:0] CH_LOCAL = REG_LOCAL_TEMP[2:0];
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [7:0] VALUE_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] LIM_HI_VOLT_RESET = 8'hFF;
  localparam logic [7:0] LIM_LO_VOLT_RESET = 8'h00;
  localparam logic [7:0] LIM_HI_TEMP_RESET = 8'h7F;
  localparam logic [7:0] LIM_LO_TEMP_RESET = 8'h80;

  typedef enum logic [2:0] {
    PS_IDLE = 3'b000,
    PS_ADDR = 3'b001,
    PS_PTR = 3'b010,
    PS_DATA = 3'b011,
    PS_READ = 3'b100,
    PS_SKIP = 3'b101
  } mar_proto_t;

  typedef enum logic [1:0] {
    SQ_IDLE = 2'b00,
    SQ_START = 2'b01,
    SQ_WAIT = 2'b10
  } mar_seq_t;

  function automatic logic mar_is_temp(input logic [2:0] ch);
    return (ch == CH_REMOTE) || (ch == CH_LOCAL);
  endfunction : mar_is_temp

  // Temperatures compare signed, voltages unsigned
  function automatic logic mar_out_of_limit(input logic [2:0] ch, input logic [7:0] val,
                                            input logic [7:0] hi, input logic [7:0] lo);
    if (mar_is_temp(ch)) begin
      return ($signed(val) > $signed(hi)) || ($signed(val) < $signed(lo));
    end
    return (val > hi) || (val < lo);
  endfunction : mar_out_of_limit
endpackage : mar_pkg

// ==== testbench/mar_monitor_properties.sv ====
// Port timing checker for the monitor result logic
`timescale 1ns/1ps
`default_nettype none
module mar_monitor_properties
  import mar_pkg::*;
#(
  parameter int CONV_CYC = CONV_CYCLES,
  parameter int REMOTE_SUB_CYC = REMOTE_SUB_CYCLES
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic SCL,
  input wire logic SDA_OUT,
  input wire logic SDA_OE_N,
  input wire logic ADC_DONE,
  input wire logic ADC_START,
  input wire logic [2:0] ADC_CHANNEL
);
  logic [17:0] gap;
  logic [2:0] last_ch;
  logic [4:0] rem_n;
  logic have_last;
  logic done_seen;
  logic [2:0] next_ch;
  // Channel expected at the next start if the sequence keeps running
  assign next_ch = (last_ch == CH_REMOTE && rem_n < 5'h10) ? CH_REMOTE : last_ch + 3'h1;
  always_ff @(posedge CLK) begin
    if (RESET) begin
      gap <= 18'h00000;
      last_ch <= CH_FIRST;
      rem_n <= 5'h00;
      have_last <= 1'b0;
      done_seen <= 1'b0;
    end else if (ADC_START) begin
      gap <= 18'h00001;
      last_ch <= ADC_CHANNEL;
      rem_n <= (ADC_CHANNEL == CH_REMOTE) ? rem_n + 5'h01 : 5'h00;
      have_last <= 1'b1;
      done_seen <= 1'b0;
    end else begin
      gap <= (gap == 18'h3FFFF) ? gap : gap + 18'h00001;
      done_seen <= done_seen | ADC_DONE;
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  reset_state_a: assert property (disable iff (1'b0)
    RESET |=> SDA_OE_N && !SDA_OUT && !ADC_START && ADC_CHANNEL == CH_FIRST)
    else $error("outputs not idle after reset");
  idle_start_a: assert property ($fell(RESET) |-> !ADC_START [*8])
    else $error("conversion started while stopped");
  start_pulse_a: assert property (ADC_START |=> !ADC_START ##1 !ADC_START)
    else $error("start pulse too long");
  slot_len_a: assert property (ADC_START && have_last && last_ch != CH_REMOTE
    |-> int'(gap) == CONV_CYC || (ADC_CHANNEL == CH_FIRST && int'(gap) > CONV_CYC))
    else $error("conversion slot length wrong");
  remote_len_a: assert property (ADC_START && have_last && last_ch == CH_REMOTE
    |-> int'(gap) == REMOTE_SUB_CYC || (ADC_CHANNEL == CH_FIRST && int'(gap) > REMOTE_SUB_CYC))
    else $error("remote sub slot length wrong");
  chan_order_a: assert property (ADC_START && have_last
    |-> ADC_CHANNEL == next_ch || ADC_CHANNEL == CH_FIRST) else $error("channel order wrong");
  chan_hold_a: assert property (!ADC_START |-> $stable(ADC_CHANNEL))
    else $error("channel moved inside slot");
  done_first_a: assert property (ADC_START && have_last |-> done_seen)
    else $error("slot ended without a result");
  sda_quiet_a: assert property ($changed(SDA_OE_N) |-> !SCL)
    else $error("data drive changed while clock high");
  remote_c: cover property (ADC_START && ADC_CHANNEL == CH_REMOTE);
  local_c: cover property (ADC_START && ADC_CHANNEL == CH_LOCAL);
  drive_c: cover property ($fell(SDA_OE_N));
endmodule : mar_monitor_properties
bind mar_monitor mar_monitor_properties #(
  .CONV_CYC(CONV_CYC),
  .REMOTE_SUB_CYC(REMOTE_SUB_CYC)
) i_mar_monitor_properties (
  .CLK(CLK), .RESET(RESET), .SCL(SCL), .SDA_OUT(SDA_OUT), .SDA_OE_N(SDA_OE_N),
  .ADC_DONE(ADC_DONE), .ADC_START(ADC_START), .ADC_CHANNEL(ADC_CHANNEL)
);
`default_nettype wire

// ==== testbench/mar_monitor_tb.sv ====
// Self-checking bench for the monitor result logic
`timescale 1ns/1ps
`default_nettype none
module mar_monitor_tb
  import mar_pkg::*;
;
  localparam int LIMIT = 40000;
  localparam logic [6:0] ADDR_OPEN = {ADDR_UPPER, 2'b10};
  localparam logic [6:0] ADDR_GND = {ADDR_UPPER, 2'b00};
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic addr1 = 1'b1;
  logic addr0 = 1'b0;
  logic fault = 1'b0;
  logic adc_done = 1'b0;
  logic [7:0] adc_data = 8'h00;
  logic scl, sda_low, sda_oe_n, sda_out, adc_start, res_valid, res_ack;
  logic [2:0] adc_ch, a_ch;
  logic [7:0] res_byte, exp_rem;
  logic [7:0] code [8] = '{8'h00, 8'hC0, 8'hFF, 8'hF5, 8'h40, 8'h80, 8'h00, 8'hE7};
  logic [7:0] rem_s [16];
  logic [3:0] r_idx = 4'h0;
  logic [9:0] note;
  logic [9:0] exp_q [$];
  logic [6:0] dev = ADDR_OPEN;
  wire sda;
  int err_total = 0, num_checks = 0, cyc = 0, n7 = 0, a_cnt = 0, sum = 0, seed = 60063;
  // Open-drain data line with pull-up
  assign sda = !sda_low && (sda_oe_n || sda_out);
  mar_monitor #(.CONV_CYC(20), .REMOTE_SUB_CYC(10)) i_mar_monitor (
    .CLK(clk), .RESET(reset), .SCL(scl), .SDA_IN(sda), .SDA_OUT(sda_out),
    .SDA_OE_N(sda_oe_n), .SLAVE_ADDR_BIT1(addr1), .SLAVE_ADDR_BIT0(addr0),
    .DIODE_FAULT(fault), .ADC_DONE(adc_done), .ADC_DATA(adc_data),
    .ADC_START(adc_start), .ADC_CHANNEL(adc_ch)
  );
  mar_smb_master i_mar_smb_master (
    .clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low), .res_valid(res_valid),
    .res_ack(res_ack), .res_byte(res_byte)
  );
  initial begin
    forever #25 clk = !clk;
  end
  // -----------------------------------------------------------------
  // Converter model: result four cycles after start, data toggles else
  // -----------------------------------------------------------------
  always @(posedge clk) begin
    adc_done <= 1'b0;
    adc_data <= ~adc_data;
    if (adc_start === 1'b1) begin
      a_ch <= adc_ch;
      a_cnt <= 3;
      if (adc_ch != CH_REMOTE) r_idx <= 4'h0;
    end else if (a_cnt != 0) begin
      a_cnt <= a_cnt - 1;
      if (a_cnt == 1) begin
        adc_done <= 1'b1;
        adc_data <= (a_ch == CH_REMOTE) ? rem_s[r_idx] : code[a_ch];
        if (a_ch == CH_REMOTE) r_idx <= r_idx + 4'h1;
        if (a_ch == CH_LOCAL) n7 <= n7 + 1;
      end
    end
  end
  // -----------------------------------------------------------------
  // Result checker and timeout
  // -----------------------------------------------------------------
  always @(posedge clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      err_total++;
      $display("Error %0t: run did not finish", $time);
      wrap_up();
    end
    if (res_valid === 1'b1) begin
      num_checks++;
      note = (exp_q.size() != 0) ? exp_q.pop_front() : 10'h000;
      if (res_ack !== note[8] || (note[9] && res_byte !== note[7:0])) begin
        err_total++;
        $display("Error %0t: got %h ack %b, expected %h", $time, res_byte, res_ack, note[7:0]);
      end
    end
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up
  task automatic xfer(input logic [6:0] a, input logic wp, input logic [7:0] p, input logic wd,
                      input logic [7:0] d, input logic r, input logic ack, input logic [7:0] e);
    exp_q.push_back({r, ack, e});
    i_mar_smb_master.xfer(a, wp, p, wd, d, r);
  endtask : xfer
  task automatic rd(input logic [7:0] p, input logic [7:0] e);
    xfer(dev, 1'b1, p, 1'b0, 8'h00, 1'b1, 1'b1, e);
  endtask : rd
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    xfer(dev, 1'b1, p, 1'b1, d, 1'b0, 1'b1, 8'h00);
  endtask : wr
  task automatic rounds(input int k);
    int t;
    t = n7 + k;
    for (int i = 0; i < LIMIT && n7 < t; i++) @(posedge clk);
    repeat (40) @(posedge clk);
  endtask : rounds
  initial begin
    for (int i = 0; i < 16; i++) begin
      rem_s[i] = 8'($random(seed));
      sum += int'($signed(rem_s[i]));
    end
    exp_rem = 8'(sum >>> 4);
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    repeat (3) @(posedge clk);
    rd(REG_STATUS2, STATUS_RESET);
    rd(REG_CONFIG, CONFIG_RESET);
    rd(REG_LOCAL_TEMP, VALUE_RESET);
    rd(REG_UNMAPPED, 8'h00);
    rd(REG_LIMIT_BASE, LIM_HI_VOLT_RESET);
    xfer(ADDR_GND, 1'b1, REG_CONFIG, 1'b1, 8'h01, 1'b0, 1'b0, 8'h00);
    xfer(dev, 1'b0, 8'h00, 1'b0, 8'h00, 1'b1, 1'b1, LIM_HI_VOLT_RESET);
    $display("test reset values done");
    wr(REG_LIMIT_BASE + 8'h02, 8'h10);
    wr(REG_CONFIG, 8'h01);
    rounds(2);
    wr(REG_CONFIG, 8'h00);
    repeat (400) @(posedge clk);
    for (int c = 0; c < 8; c++) begin
      rd(REG_VALUE_BASE + 8'(c), (c == 6) ? exp_rem : code[c]);
    end
    wr(REG_LOCAL_TEMP, 8'h55);
    rd(REG_LOCAL_TEMP, 8'hE7);
    rd(REG_STATUS1, 8'h02);
    xfer(dev, 1'b0, 8'h00, 1'b0, 8'h00, 1'b1, 1'b1, 8'h02);
    $display("test conversions done");
    fault <= 1'b1;
    wr(REG_CONFIG, 8'h01);
    rounds(1);
    rd(REG_STATUS2, 8'h40);
    fault <= 1'b0;
    rounds(2);
    rd(REG_STATUS2, 8'h00);
    $display("test diode fault done");
    reset <= 1'b1;
    addr1 <= 1'b0;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    repeat (3) @(posedge clk);
    dev = ADDR_GND;
    rd(REG_CONFIG, CONFIG_RESET);
    xfer(ADDR_OPEN, 1'b1, REG_CONFIG, 1'b1, 8'h01, 1'b0, 1'b0, 8'h00);
    $display("test second reset done");
    wrap_up();
  end
endmodule : mar_monitor_tb
`default_nettype wire

// ==== testbench/mar_smb_master.sv ====
// Serial bus master model issuing write, pointer-only and read transfers
`timescale 1ns/1ps
`default_nettype none
module mar_smb_master (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_low,
  output logic res_valid,
  output logic res_ack,
  output logic [7:0] res_byte
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    res_valid = 1'b0;
    res_ack = 1'b0;
    res_byte = 8'h00;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  // Data moves mid-low and is sampled mid-high
  task automatic bit_io(input logic b, output logic r);
    sda_low <= !b;
    tick(4);
    scl <= 1'b1;
    tick(4);
    #1 r = sda;
    tick(4);
    scl <= 1'b0;
    tick(4);
  endtask : bit_io
  task automatic start();
    sda_low <= 1'b0;
    tick(4);
    scl <= 1'b1;
    tick(4);
    sda_low <= 1'b1;
    tick(4);
    scl <= 1'b0;
    tick(4);
  endtask : start
  task automatic put(input logic [7:0] v, inout logic ok);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(v[i], r);
    bit_io(1'b1, r);
    if (r) ok = 1'b0;
  endtask : put
  task automatic xfer(input logic [6:0] a, input logic wp, input logic [7:0] p,
                      input logic wd, input logic [7:0] d, input logic rd);
    logic ok;
    logic r;
    logic [7:0] q;
    ok = 1'b1;
    q = 8'h00;
    start();
    if (wp) begin
      put({a, 1'b0}, ok);
      put(p, ok);
      if (wd) put(d, ok);
      if (rd) start();
    end
    if (rd) begin
      put({a, 1'b1}, ok);
      for (int i = 7; i >= 0; i--) bit_io(1'b1, q[i]);
      bit_io(1'b1, r);
    end
    sda_low <= 1'b1;
    tick(4);
    scl <= 1'b1;
    tick(4);
    sda_low <= 1'b0;
    tick(8);
    res_ack <= ok;
    res_byte <= q;
    res_valid <= 1'b1;
    tick(1);
    res_valid <= 1'b0;
  endtask : xfer
endmodule : mar_smb_master
`default_nettype wire
